// [tb/smb_board_model.sv]
// Board model: mode strap pins and debugger attach line
`timescale 1ns/100ps
module smb_board_model
(
    // Clock
    input  wire logic sys_clk,
    // Levels asked for by the bench
    input  wire logic want_boot,
    input  wire logic want_harv,
    input  wire logic want_swd,
    // Board pins
    output logic      boot_mode_select_pin,
    output logic      harvest_mode_select_pin,
    output logic      swd_attach_pin
);
    ////////////////////////////////////////////////////////////////////////
    // Straps start at the filter reset levels
    initial
    begin
        boot_mode_select_pin    = 1'b1;
        harvest_mode_select_pin = 1'b0;
        swd_attach_pin          = 1'b0;
    end

    // Straps only move when the bench asks, never around release
    always @(posedge sys_clk)
    begin
        boot_mode_select_pin    <= want_boot;
        harvest_mode_select_pin <= want_harv;
        swd_attach_pin          <= want_swd;
    end
endmodule

// [tb/tb_startup_mode_backbias_ctrl.sv]
// Self-checking testbench for the startup mode and back-bias block
`timescale 1ns/100ps
module tb_startup_mode_backbias_ctrl
    import smb_pkg::*;
;
    ////////////////////////////////////////////////////////////////////////
    logic sys_clk          = 1'b0;
    logic reset            = 1'b1;
    logic ce               = 1'b1;
    logic bias_enable_wr   = 1'b0;
    logic bias_enable_data = 1'b0;
    logic low_leak_req     = 1'b0;
    logic want_boot        = 1'b1;
    logic want_harv        = 1'b0;
    logic want_swd         = 1'b0;
    logic boot_pin;
    logic harv_pin;
    logic swd_pin;
    logic en_bit;
    logic done_flag;
    logic low_leak_grant;
    logic charge_en;
    logic internal_reset;
    logic serial_boot_mode;
    logic flash_exec_en;
    logic serial_if_en;
    logic pins_general_en;
    logic debug_accept;
    int   fails      = 0;
    int   n_compared = 0;
    int   n_norm     = 0;
    int   n_run      = 0;
    int   k          = 0;

    always #12.5 sys_clk = ~sys_clk;

    smb_board_model board_u (
        .sys_clk                 (sys_clk),
        .want_boot               (want_boot),
        .want_harv               (want_harv),
        .want_swd                (want_swd),
        .boot_mode_select_pin    (boot_pin),
        .harvest_mode_select_pin (harv_pin),
        .swd_attach_pin          (swd_pin)
    );

    smb_startup_ctrl dut_u (
        .sys_clk                   (sys_clk),
        .reset                     (reset),
        .ce                        (ce),
        .boot_mode_select_pin      (boot_pin),
        .harvest_mode_select_pin   (harv_pin),
        .swd_attach_pin            (swd_pin),
        .bias_enable_wr            (bias_enable_wr),
        .bias_enable_data          (bias_enable_data),
        .low_leak_req              (low_leak_req),
        .back_bias_enable_bit      (en_bit),
        .back_bias_setup_done_flag (done_flag),
        .low_leak_grant            (low_leak_grant),
        .back_bias_charge_en       (charge_en),
        .internal_reset            (internal_reset),
        .serial_boot_mode          (serial_boot_mode),
        .flash_exec_en             (flash_exec_en),
        .serial_if_en              (serial_if_en),
        .pins_general_en           (pins_general_en),
        .debug_accept              (debug_accept)
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic seen, input logic exp, input string what);
        n_compared++;
        if (seen !== exp)
        begin
            fails++;
            $display("CHECK FAILED at %0t: %s", $time, what);
        end
    endtask

    task automatic end_of_test;
        $display("Compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Straps settle well before release and stay put after it
    task automatic start_up(input logic b, input logic h, output int cyc);
        @(posedge sys_clk);
        want_boot <= b;
        want_harv <= h;
        reset     <= 1'b1;
        repeat (8) @(posedge sys_clk);
        reset <= 1'b0;
        cyc = 0;
        @(negedge sys_clk);
        while (internal_reset !== 1'b0 && cyc < 5000)
        begin
            @(negedge sys_clk);
            cyc++;
        end
    endtask

    task automatic write_enable(input logic v);
        @(posedge sys_clk);
        bias_enable_wr   <= 1'b1;
        bias_enable_data <= v;
        @(posedge sys_clk);
        bias_enable_wr <= 1'b0;
        repeat (2) @(negedge sys_clk);
    endtask

    task automatic run_checks(input logic ser, input string what);
        check(serial_boot_mode, ser, what);
        check(serial_if_en, ser, what);
        check(flash_exec_en, ~ser, what);
        check(pins_general_en, ~ser, what);
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic scen_serial;
        for (int h = 0; h < 2; h++)
        begin
            start_up(1'b0, h[0], n_run);
            check(n_run <= int'(NORM_RST_CYC) + 8, 1'b1, "serial reset len");
            run_checks(1'b1, "serial boot outputs");
            want_boot <= 1'b1;
            want_harv <= ~h[0];
            repeat (12) @(negedge sys_clk);
            run_checks(1'b1, "serial mode not latched");
        end
    endtask

    task automatic scen_normal;
        start_up(1'b1, 1'b0, n_norm);
        check(n_norm >= int'(NORM_RST_CYC), 1'b1, "normal reset short");
        check(n_norm <= int'(NORM_RST_CYC) + 8, 1'b1, "normal reset long");
        run_checks(1'b0, "normal outputs");
        check(en_bit, 1'b0, "bias enabled at normal start");
        check(done_flag, 1'b0, "done set at normal start");
        @(posedge sys_clk);
        low_leak_req <= 1'b1;
        repeat (4) @(negedge sys_clk);
        check(low_leak_grant, 1'b0, "grant without setup");
        write_enable(1'b1);
        check(en_bit, 1'b1, "enable bit not set");
        k = 0;
        while (charge_en !== 1'b1 && k < 6)
        begin
            @(negedge sys_clk);
            k++;
        end
        check(charge_en, 1'b1, "charge did not start");
        check(done_flag, 1'b0, "done before charge");
        k = 0;
        while (done_flag !== 1'b1 && k < int'(CHARGE_CYC) + 20)
        begin
            @(negedge sys_clk);
            k++;
        end
        check(done_flag, 1'b1, "setup never finished");
        check(k >= int'(CHARGE_CYC) - 5, 1'b1, "charge too short");
        check(charge_en, 1'b0, "charge still on");
        repeat (2) @(negedge sys_clk);
        check(low_leak_grant, 1'b1, "no grant with setup done");
        write_enable(1'b1);
        check(done_flag, 1'b1, "rewrite of 1 disturbed done");
        write_enable(1'b0);
        check(en_bit, 1'b0, "enable bit not cleared");
        repeat (2) @(negedge sys_clk);
        check(done_flag, 1'b0, "done kept after disable");
        check(low_leak_grant, 1'b0, "grant kept after disable");
        @(posedge sys_clk);
        low_leak_req <= 1'b0;
    endtask

    task automatic scen_harvest;
        start_up(1'b1, 1'b1, n_run);
        check(n_run > n_norm, 1'b1, "harvest reset not longer");
        check(n_run >= int'(HARV_RST_CYC), 1'b1, "harvest reset short");
        check(n_run <= int'(HARV_RST_CYC) + 8, 1'b1, "harvest reset long");
        check(en_bit, 1'b1, "harvest enable bit");
        check(done_flag, 1'b1, "harvest done flag");
        check(charge_en, 1'b0, "harvest charge left on");
        run_checks(1'b0, "harvest outputs");
        @(posedge sys_clk);
        low_leak_req <= 1'b1;
        repeat (3) @(negedge sys_clk);
        check(low_leak_grant, 1'b1, "harvest grant");
        @(posedge sys_clk);
        low_leak_req <= 1'b0;
        want_boot    <= 1'b0;
        want_harv    <= 1'b0;
        repeat (12) @(negedge sys_clk);
        run_checks(1'b0, "harvest mode not latched");
        check(low_leak_grant, 1'b0, "grant without request");
    endtask

    task automatic scen_debug;
        // Enable low must freeze the pin filter as well
        @(posedge sys_clk);
        ce       <= 1'b0;
        want_swd <= 1'b1;
        repeat (10) @(negedge sys_clk);
        check(debug_accept, 1'b0, "state moved with enable low");
        @(posedge sys_clk);
        ce <= 1'b1;
        repeat (10) @(negedge sys_clk);
        check(debug_accept, 1'b1, "debugger not accepted");
        want_swd <= 1'b0;
        repeat (10) @(negedge sys_clk);
        check(debug_accept, 1'b0, "debugger still accepted");
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Whole run is about 8000 cycles; the limit leaves ample margin
    initial
    begin
        #(25 * 40000);
        fails++;
        $display("CHECK FAILED at %0t: run timed out", $time);
        end_of_test();
    end

    initial
    begin
        repeat (3) @(posedge sys_clk);
        reset <= 1'b0;
        scen_normal();
        scen_debug();
        scen_harvest();
        scen_serial();
        end_of_test();
    end
endmodule

// [verilog/smb_bias_if.sv]
// Link between the startup controller and the back-bias sequencer
`timescale 1ns/100ps
interface smb_bias_if;
    logic ce;
    logic start;
    logic abort;
    logic charging;
    logic done;

    modport ctrl (output ce, output start, output abort,
                  input charging, input done);
    modport seq  (input ce, input start, input abort,
                  output charging, output done);
endinterface

// [verilog/smb_bias_seq.sv]
// Back-bias initial setup sequencer: capacitor charge timing
`timescale 1ns/100ps
module smb_bias_seq
    import smb_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // Controller link
    smb_bias_if.seq  bias
);

    smb_bias_t r_reg;
    smb_bias_t r_next;

    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        r_next = r_reg;
        unique case (r_reg.state)
            BS_IDLE:
            begin
                if (bias.start)
                begin
                    r_next.state    = BS_CHARGE;
                    r_next.cnt      = smb_cnt_t'(0);
                    r_next.charging = 1'b1;
                end
            end
            BS_CHARGE:
            begin
                // Completion beats a disable in the same cycle
                if (r_reg.cnt == CHARGE_CYC - smb_cnt_t'(1))
                begin
                    r_next.state    = BS_READY;
                    r_next.done     = 1'b1;
                    r_next.charging = 1'b0;
                end
                else if (bias.abort)
                begin
                    r_next.state    = BS_IDLE;
                    r_next.charging = 1'b0;
                end
                else
                begin
                    r_next.cnt = r_reg.cnt + smb_cnt_t'(1);
                end
            end
            BS_READY:
            begin
                if (bias.abort)
                begin
                    r_next.state = BS_IDLE;
                    r_next.done  = 1'b0;
                end
            end
            default:
            begin
                r_next = SMB_BIAS_RST;
            end
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
            r_reg <= SMB_BIAS_RST;
        else if (bias.ce)
            r_reg <= r_next;
    end

    assign bias.charging = r_reg.charging;
    assign bias.done     = r_reg.done;

    ////////////////////////////////////////////////////////////////////////
    chk_start_charges: assert property (
        @(posedge sys_clk) disable iff (reset)
        (bias.ce && bias.start && r_reg.state == BS_IDLE)
            |=> (bias.charging && r_reg.cnt == smb_cnt_t'(0)))
        else $error("start did not begin capacitor charge");

    chk_done_on_time: assert property (
        @(posedge sys_clk) disable iff (reset)
        (bias.ce && r_reg.state == BS_CHARGE
            && r_reg.cnt == CHARGE_CYC - smb_cnt_t'(1))
            |=> (bias.done && !bias.charging))
        else $error("setup done flag not set at charge end");

endmodule

// [verilog/smb_pkg.sv]
// Constants, types and reset values for the startup and back-bias block
package smb_pkg;

    ////////////////////////////////////////////////////////////////////////
    localparam int CLK_PERIOD_NS = 25;
    localparam int CNT_W         = 13;
    typedef logic [CNT_W-1:0] smb_cnt_t;

    // Times in ns, counts in sys_clk cycles, rounded up
    localparam int NORM_RST_NS = 10000;
    localparam int HARV_RST_NS = 100000;
    localparam int CHARGE_NS   = 50000;
    localparam smb_cnt_t NORM_RST_CYC =
        smb_cnt_t'((NORM_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam smb_cnt_t HARV_RST_CYC =
        smb_cnt_t'((HARV_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam smb_cnt_t CHARGE_CYC =
        smb_cnt_t'((CHARGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    // Three stages, the agree stage and the sampling edge; fewer reads the reset level
    localparam smb_cnt_t SYNC_FILL_CYC = smb_cnt_t'(5);

    ////////////////////////////////////////////////////////////////////////
    typedef enum logic [1:0] {
        ST_SYNC = 2'b00,
        ST_IRST = 2'b01,
        ST_RUN  = 2'b10
    } smb_top_state_t;

    typedef enum logic [1:0] {
        MODE_NORMAL  = 2'b00,
        MODE_HARVEST = 2'b01,
        MODE_SERIAL  = 2'b10
    } smb_mode_t;

    typedef enum logic [1:0] {
        BS_IDLE   = 2'b00,
        BS_CHARGE = 2'b01,
        BS_READY  = 2'b10
    } smb_bias_state_t;

    ////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        smb_top_state_t state;
        smb_mode_t      mode;
        smb_cnt_t       cnt;
        logic [2:0]     boot_sync;
        logic [2:0]     harv_sync;
        logic [2:0]     dbg_sync;
        logic           boot_lvl;
        logic           harv_lvl;
        logic           dbg_lvl;
        logic           bias_en;
        logic           bias_start;
        logic           bias_abort;
        logic           bias_done;
        logic           charge_en;
        logic           int_reset;
        logic           serial_boot;
        logic           flash_exec;
        logic           serial_if_en;
        logic           pins_general;
        logic           dbg_accept;
        logic           low_leak_grant;
    } smb_top_t;

    localparam smb_top_t SMB_TOP_RST = '{
        state: ST_SYNC, mode: MODE_NORMAL, cnt: smb_cnt_t'(0),
        boot_sync: 3'h7, harv_sync: 3'h0, dbg_sync: 3'h0,
        boot_lvl: 1'h1, harv_lvl: 1'h0, dbg_lvl: 1'h0,
        bias_en: 1'h0, bias_start: 1'h0, bias_abort: 1'h0,
        bias_done: 1'h0, charge_en: 1'h0, int_reset: 1'h1,
        serial_boot: 1'h0, flash_exec: 1'h0, serial_if_en: 1'h0,
        pins_general: 1'h0, dbg_accept: 1'h0, low_leak_grant: 1'h0
    };

    typedef struct packed {
        smb_bias_state_t state;
        smb_cnt_t        cnt;
        logic            charging;
        logic            done;
    } smb_bias_t;

    localparam smb_bias_t SMB_BIAS_RST = '{
        state: BS_IDLE, cnt: smb_cnt_t'(0), charging: 1'h0, done: 1'h0
    };

endpackage

// [verilog/smb_startup_ctrl.sv]
// Startup mode selection and back-bias setup control, top level
// What this block does
// - Boot pin low at reset release selects serial boot, harvest pin ignored.
// - Boot pin high at release starts normal or harvest mode from flash.
// - With boot pin high, harvest pin low means normal, high means harvest.
// - Serial boot runs the internal boot program and enables the serial port.
// - Normal and harvest modes free every pin for general use.
// - Debug mode accepts external control through the debug wire link.
// - Normal startup leaves the back-bias controller off until software acts.
// - Writing enable 1 starts back-bias setup, charging the external capacitor.
// - Setup completion sets the back-bias setup-done flag.
// - Low leakage entry is granted only if setup-done read 1 in the cycle before.
// - Harvest startup completes back-bias setup inside internal reset.
// - Harvest internal reset period is longer than the normal one.
`timescale 1ns/100ps
module smb_startup_ctrl
    import smb_pkg::*;
(
    // Clock, reset, enable
    input  wire logic sys_clk,
    input  wire logic reset,
    input  wire logic ce,
    // Board pins
    input  wire logic boot_mode_select_pin,
    input  wire logic harvest_mode_select_pin,
    input  wire logic swd_attach_pin,
    // Software control
    input  wire logic bias_enable_wr,
    input  wire logic bias_enable_data,
    input  wire logic low_leak_req,
    // Software status
    output logic      back_bias_enable_bit,
    output logic      back_bias_setup_done_flag,
    output logic      low_leak_grant,
    // Back-bias capacitor charge drive
    output logic      back_bias_charge_en,
    // Startup outputs
    output logic      internal_reset,
    output logic      serial_boot_mode,
    output logic      flash_exec_en,
    output logic      serial_if_en,
    output logic      pins_general_en,
    output logic      debug_accept
);

    smb_top_t   r_reg;
    smb_top_t   r_next;
    smb_cnt_t   irst_limit;
    smb_bias_if bias ();

    ////////////////////////////////////////////////////////////////////////
    // Harvest waits longer so the capacitor charges during reset
    assign irst_limit = (r_reg.mode == MODE_HARVEST) ? HARV_RST_CYC
                                                     : NORM_RST_CYC;

    always_comb
    begin
        r_next            = r_reg;
        r_next.bias_start = 1'b0;
        r_next.bias_abort = 1'b0;
        r_next.boot_sync  = {r_reg.boot_sync[1:0], boot_mode_select_pin};
        r_next.harv_sync  = {r_reg.harv_sync[1:0], harvest_mode_select_pin};
        r_next.dbg_sync   = {r_reg.dbg_sync[1:0], swd_attach_pin};
        // Level accepted only once second and third stages agree
        if (r_reg.boot_sync[2] == r_reg.boot_sync[1])
            r_next.boot_lvl = r_reg.boot_sync[2];
        if (r_reg.harv_sync[2] == r_reg.harv_sync[1])
            r_next.harv_lvl = r_reg.harv_sync[2];
        if (r_reg.dbg_sync[2] == r_reg.dbg_sync[1])
            r_next.dbg_lvl = r_reg.dbg_sync[2];
        r_next.bias_done = bias.done;
        r_next.charge_en = bias.charging;
        unique case (r_reg.state)
            ST_SYNC:
            begin
                r_next.cnt = r_reg.cnt + smb_cnt_t'(1);
                // Pins must be stable across release for this sample
                if (r_reg.cnt == SYNC_FILL_CYC - smb_cnt_t'(1))
                begin
                    r_next.state = ST_IRST;
                    r_next.cnt   = smb_cnt_t'(0);
                    if (!r_reg.boot_lvl)
                        r_next.mode = MODE_SERIAL;
                    else if (r_reg.harv_lvl)
                    begin
                        r_next.mode       = MODE_HARVEST;
                        r_next.bias_en    = 1'b1;
                        r_next.bias_start = 1'b1;
                    end
                    else
                        r_next.mode = MODE_NORMAL;
                end
            end
            ST_IRST:
            begin
                r_next.cnt = r_reg.cnt + smb_cnt_t'(1);
                if (r_reg.cnt >= irst_limit - smb_cnt_t'(1)
                    && (r_reg.mode != MODE_HARVEST || r_reg.bias_done))
                begin
                    r_next.state        = ST_RUN;
                    r_next.int_reset    = 1'b0;
                    r_next.serial_boot  = (r_reg.mode == MODE_SERIAL);
                    r_next.serial_if_en = (r_reg.mode == MODE_SERIAL);
                    r_next.flash_exec   = (r_reg.mode != MODE_SERIAL);
                    r_next.pins_general = (r_reg.mode != MODE_SERIAL);
                end
            end
            ST_RUN:
            begin
                // Mode stays frozen here until the next reset
                if (bias_enable_wr)
                begin
                    r_next.bias_en    = bias_enable_data;
                    r_next.bias_start = bias_enable_data && !r_reg.bias_en;
                    r_next.bias_abort = !bias_enable_data && r_reg.bias_en;
                end
                r_next.dbg_accept     = r_reg.dbg_lvl;
                r_next.low_leak_grant = low_leak_req && r_reg.bias_done;
            end
            default:
            begin
                r_next = SMB_TOP_RST;
            end
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
            r_reg <= SMB_TOP_RST;
        else if (ce)
            r_reg <= r_next;
    end

    ////////////////////////////////////////////////////////////////////////
    assign bias.ce    = ce;
    assign bias.start = r_reg.bias_start;
    assign bias.abort = r_reg.bias_abort;

    smb_bias_seq u_bias_seq (
        .sys_clk (sys_clk),
        .reset   (reset),
        .bias    (bias.seq)
    );

    assign back_bias_enable_bit      = r_reg.bias_en;
    assign back_bias_setup_done_flag = r_reg.bias_done;
    assign low_leak_grant            = r_reg.low_leak_grant;
    assign back_bias_charge_en       = r_reg.charge_en;
    assign internal_reset            = r_reg.int_reset;
    assign serial_boot_mode          = r_reg.serial_boot;
    assign flash_exec_en             = r_reg.flash_exec;
    assign serial_if_en              = r_reg.serial_if_en;
    assign pins_general_en           = r_reg.pins_general;
    assign debug_accept              = r_reg.dbg_accept;

    ////////////////////////////////////////////////////////////////////////
    chk_serial_select: assert property (
        @(posedge sys_clk) disable iff (reset)
        (ce && r_reg.state == ST_SYNC && !r_reg.boot_lvl
            && r_reg.cnt == SYNC_FILL_CYC - smb_cnt_t'(1))
            |=> (r_reg.mode == MODE_SERIAL))
        else $error("boot pin low did not select serial boot");

    chk_flash_start: assert property (
        @(posedge sys_clk) disable iff (reset)
        (r_reg.state == ST_RUN)
            |-> (flash_exec_en == (r_reg.mode != MODE_SERIAL)
                 && serial_boot_mode == (r_reg.mode == MODE_SERIAL)))
        else $error("flash execution does not match mode");

    chk_harvest_pick: assert property (
        @(posedge sys_clk) disable iff (reset)
        (ce && r_reg.state == ST_SYNC && r_reg.boot_lvl
            && r_reg.cnt == SYNC_FILL_CYC - smb_cnt_t'(1))
            |=> (r_reg.mode == ($past(r_reg.harv_lvl) ? MODE_HARVEST
                                                       : MODE_NORMAL)))
        else $error("harvest pin sampled wrongly");

    chk_serial_port_on: assert property (
        @(posedge sys_clk) disable iff (reset)
        (r_reg.state == ST_RUN)
            |-> (serial_if_en == (r_reg.mode == MODE_SERIAL)))
        else $error("serial port enable does not match mode");

    chk_pins_general: assert property (
        @(posedge sys_clk) disable iff (reset)
        (r_reg.state == ST_RUN && r_reg.mode != MODE_SERIAL)
            |-> pins_general_en)
        else $error("pins not released for general use");

    chk_debug_accept: assert property (
        @(posedge sys_clk) disable iff (reset)
        (ce && r_reg.state == ST_RUN && r_reg.dbg_lvl) |=> debug_accept)
        else $error("debug attach not accepted");

    chk_bias_off_normal: assert property (
        @(posedge sys_clk) disable iff (reset)
        ($rose(r_reg.state == ST_RUN) && r_reg.mode != MODE_HARVEST)
            |-> (!back_bias_enable_bit && !back_bias_setup_done_flag))
        else $error("back bias active after non-harvest startup");

    chk_grant_gate: assert property (
        @(posedge sys_clk) disable iff (reset)
        low_leak_grant |-> $past(r_reg.bias_done))
        else $error("low leakage granted before setup done");

    chk_harvest_ready: assert property (
        @(posedge sys_clk) disable iff (reset)
        ($rose(r_reg.state == ST_RUN) && r_reg.mode == MODE_HARVEST)
            |-> (back_bias_enable_bit && back_bias_setup_done_flag))
        else $error("harvest release without completed setup");

    chk_irst_length: assert property (
        @(posedge sys_clk) disable iff (reset)
        $fell(internal_reset)
            |-> ($past(r_reg.cnt) >= ((r_reg.mode == MODE_HARVEST)
                 ? HARV_RST_CYC : NORM_RST_CYC) - smb_cnt_t'(1)))
        else $error("internal reset period too short");

    chk_mode_hold: assert property (
        @(posedge sys_clk) disable iff (reset)
        (r_reg.state == ST_RUN) |=> (r_reg.state == ST_RUN && $stable(r_reg.mode)))
        else $error("startup mode changed after release");

endmodule
